// ==== logic/fws_status_reporter.sv ====
// Design decisions made here: the plain strobed port and the placing of the registers.
`include "fws_status_cfg.svh"

//==========================================================================
// Write operation status reporter.
module fws_status_reporter
   import fws_pkg::*;
#(
   parameter int unsigned PROT_PROG_CYC =
      (`FWS_PROT_PROG_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS,
   parameter int unsigned PROT_SECT_CYC =
      (`FWS_PROT_SECT_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS,
   parameter int unsigned PROT_ALL_CYC =
      (`FWS_PROT_ALL_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS,
   parameter int unsigned READY_CYC =
      (`FWS_READY_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS,
   parameter int unsigned RH_CYC =
      (`FWS_RH_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS
) (
   // Clock and reset.
   input  wire logic  i_clk,
   input  wire logic  i_srst,
   // Device pins.
   input  wire logic  i_write_strobe_n,
   input  wire logic  i_output_enable_n,
   input  wire logic  i_chip_select_n,
   input  wire logic  i_address_valid_n,
   input  wire logic  i_burst_clk,
   input  wire logic  i_hw_reset_n,
   // Core side inputs.
   input  wire logic  i_sync_mode,
   input  fws_cmd_t   i_cmd,
   input  fws_eng_t   i_eng,
   input  fws_rd_t    i_rd,
   // Status and control outputs.
   output fws_stat_t  o_stat,
   output fws_ctl_t   o_ctl,
   output logic       o_cmd_reject,
   output logic       o_read_ok,
   // Open-drain ready/busy pin.
   output logic       o_ready_busy_n_out,
   output logic       o_ready_busy_n_oe_n
);

   localparam int CW = `FWS_CNT_W;
   localparam int NP = `FWS_NPIN;

   //=======================================================================
   // Declarations.
   logic [NP-1:0] pin_raw;     // Raw pin levels.
   logic [NP-1:0] sync1;       // First synchroniser stage.
   logic [NP-1:0] sync2;       // Second synchroniser stage.
   logic [NP-1:0] sync3;       // Third synchroniser stage.
   logic [NP-1:0] flt;         // Accepted pin levels.
   logic [NP-1:0] flt_q;       // Accepted levels one cycle back.
   logic [NP-1:0] rise;        // Rising edges of accepted levels.
   logic          we_rise;     // Write strobe closed.
   logic          rd_end;      // A read cycle ended.
   logic          rst_low;     // Hardware reset held.
   fws_cmd_t      pend;        // Command waiting for its strobe edge.
   logic          cmd_go;      // Command takes effect now.
   fws_state_t    state;       // Current state.
   fws_state_t    next_state;  // State for the next cycle.
   logic [CW-1:0] cnt;         // Timer for timed states.
   logic [CW-1:0] next_cnt;    // Timer value for the next cycle.
   logic          tog1;        // First toggle bit.
   logic          tog2;        // Second toggle bit.
   logic          busy7;       // Polling bit shown while busy.
   logic          next_busy7;  // Next polling bit while busy.
   logic          done7;       // True bit shown after completion.
   logic          next_done7;  // Next true bit.
   logic          done_pend;   // One more status read is owed.
   logic          done_set;    // Completion seen this cycle.
   logic [CW-1:0] rh_cnt;      // Delay from reset release to reads.
   fws_stat_t     next_stat;   // Status for the next cycle.
   fws_ctl_t      next_ctl;    // Engine controls for the next cycle.
   logic          next_reject; // Rejection pulse for the next cycle.
   logic          busy_state;  // State drives the busy line low.
   logic          tog_state;   // State makes the first toggle run.
   logic          pe_cmd;      // Pending command is program or erase.

   assign pin_raw = {i_hw_reset_n, i_burst_clk, i_address_valid_n,
                     i_chip_select_n, i_output_enable_n, i_write_strobe_n};

   //=======================================================================
   // Pin synchronisers.
   // Three stages per pin; only the second stage reads the first.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sync1 <= `FWS_PIN_IDLE;
         sync2 <= `FWS_PIN_IDLE;
         sync3 <= `FWS_PIN_IDLE;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // A level is accepted only once the second and third stages agree.
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_flt
         always_ff @(posedge i_clk) begin
            if (i_srst) begin
               flt[gi]   <= 1'(`FWS_PIN_IDLE >> gi);
               flt_q[gi] <= 1'(`FWS_PIN_IDLE >> gi);
            end else begin
               if (sync2[gi] == sync3[gi]) begin
                  flt[gi] <= sync3[gi];
               end
               flt_q[gi] <= flt[gi];
            end
         end
      end
   endgenerate

   assign rise    = flt & ~flt_q;
   assign we_rise = rise[`FWS_PIN_WE];
   assign rst_low = ~flt[`FWS_PIN_RST];

   // A read ends when its enable or select rises in asynchronous mode, or on the valid pin
   // or burst clock edges in synchronous mode.
   assign rd_end = i_sync_mode ?
      (rise[`FWS_PIN_ADV] |
       (rise[`FWS_PIN_BCLK] & ~flt[`FWS_PIN_ADV])) :
      ((rise[`FWS_PIN_OE] & ~flt_q[`FWS_PIN_CS]) |
       (rise[`FWS_PIN_CS] & ~flt_q[`FWS_PIN_OE]));    // RULE19

   //=======================================================================
   // Pending command.
   // Held until the closing strobe edge; a new command wins over use.
   assign cmd_go = we_rise & pend.valid;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pend <= '0;
      end else if (i_cmd.valid) begin
         pend <= i_cmd;
      end else if (cmd_go | rst_low) begin
         pend <= '0;
      end
   end

   //=======================================================================
   // State decode helpers.
   // Idle and suspend leave the busy line free; all else holds it.
   assign busy_state = (state != FWS_S_IDLE) && (state != FWS_S_SUSP);
   // The first toggle runs while busy, except in reset recovery.
   assign tog_state  = busy_state && (state != FWS_S_RBUSY); // RULE17 RULE20
   // Program and erase commands are the ones a busy device refuses.
   assign pe_cmd     = (pend.kind == FWS_CMD_PROG) ||
                       (pend.kind == FWS_CMD_CHIP) ||
                       (pend.kind == FWS_CMD_SECT);            // RULE13

   //=======================================================================
   // Next state, timer and engine controls.
   always_comb begin
      next_state  = state;
      next_cnt    = (cnt != '0) ? cnt - CW'(1) : cnt;
      next_busy7  = busy7;
      next_done7  = done7;
      next_ctl    = '0;
      next_reject = 1'b0;
      done_set    = 1'b0;
      if (rst_low && state != FWS_S_RBUSY) begin
         // Reset during an operation keeps the line busy a while.
         next_ctl.abort = busy_state;
         next_state = busy_state ? FWS_S_RBUSY : FWS_S_IDLE; // RULE16
         next_cnt   = CW'(READY_CYC);
      end else begin
         case (state)
            FWS_S_IDLE: begin
               if (cmd_go) begin
                  case (pend.kind)
                     FWS_CMD_PROG: begin
                        next_busy7 = ~pend.data7;       // RULE1
                        next_done7 = pend.data7;
                        if (pend.target_prot) begin
                           next_state = FWS_S_PPROT;    // RULE8 RULE21
                           next_cnt   = CW'(PROT_PROG_CYC);
                        end else begin
                           next_state = FWS_S_PROG;     // RULE15
                           next_ctl.start_prog = 1'b1;
                        end
                     end
                     FWS_CMD_CHIP, FWS_CMD_SECT: begin
                        next_busy7 = 1'b0;              // RULE5
                        next_done7 = 1'b1;
                        if (pend.all_prot) begin
                           next_state = FWS_S_EPROT;
                           if (pend.kind == FWS_CMD_SECT && !pend.multi) begin
                              next_cnt = CW'(PROT_SECT_CYC); // RULE9
                           end else begin
                              next_cnt = CW'(PROT_ALL_CYC);  // RULE10
                           end
                        end else begin
                           // Chip or sector erase starts at this edge.
                           next_state = FWS_S_ERASE;    // RULE3 RULE4
                           next_ctl.start_erase = 1'b1;
                           next_ctl.skip_prot = pend.some_prot; // RULE11
                        end
                     end
                     default: next_state = FWS_S_IDLE;
                  endcase
               end
            end
            FWS_S_PROG, FWS_S_ERASE: begin
               if (i_eng.pulse_limit) begin
                  next_state = FWS_S_FAIL;              // RULE24
               end else if (i_eng.done) begin
                  next_state = FWS_S_IDLE;
                  done_set   = 1'b1;
               end else if (cmd_go) begin
                  if (pend.kind == FWS_CMD_SUSP && state == FWS_S_ERASE) begin
                     next_state = FWS_S_SUSP;           // RULE14
                     next_ctl.suspend = 1'b1;
                  end else begin
                     next_reject = pe_cmd;              // RULE13
                  end
               end
            end
            FWS_S_SUSP: begin
               if (cmd_go) begin
                  if (pend.kind == FWS_CMD_PROG && !pend.target_prot) begin
                     next_state = FWS_S_SPROG;          // RULE20
                     next_busy7 = ~pend.data7;
                     next_ctl.start_prog = 1'b1;
                  end else if (pend.kind == FWS_CMD_RESUME) begin
                     next_state = FWS_S_ERASE;
                     next_ctl.resume = 1'b1;
                  end else begin
                     next_reject = pe_cmd;
                  end
               end
            end
            FWS_S_SPROG: begin
               if (i_eng.pulse_limit) begin
                  next_state = FWS_S_FAIL;
               end else if (i_eng.done) begin
                  next_state = FWS_S_SUSP;
               end else if (cmd_go) begin
                  next_reject = pe_cmd;
               end
            end
            FWS_S_PPROT, FWS_S_EPROT: begin
               // Attempt on protected area ends without touching it.
               if (cnt == '0) begin
                  next_state = FWS_S_IDLE;
               end else if (cmd_go) begin
                  next_reject = pe_cmd;
               end
            end
            FWS_S_FAIL: begin
               // Only the reset command or a hardware reset brings back array reads.
               if (cmd_go) begin
                  if (pend.kind == FWS_CMD_RESET) begin
                     next_state     = FWS_S_IDLE;       // RULE24
                     next_ctl.abort = 1'b1;
                  end else begin
                     next_reject = pe_cmd;
                  end
               end
            end
            FWS_S_RBUSY: begin
               if (cnt == '0) begin
                  next_state = FWS_S_IDLE;              // RULE16
               end
            end
            default: next_state = FWS_S_IDLE;
         endcase
      end
   end

   // State, timer and polling values.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state <= FWS_S_IDLE;
         cnt   <= '0;
         busy7 <= 1'b0;
         done7 <= 1'b1;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         busy7 <= next_busy7;
         done7 <= next_done7;
      end
   end

   //=======================================================================
   // Toggle bits and the owed completion read.
   // Each ended read flips the toggles that are running.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         tog1 <= 1'b0;
         tog2 <= 1'b0;
      end else if (rd_end) begin
         if (tog_state) begin
            tog1 <= ~tog1;                              // RULE17 RULE18
         end
         if (i_rd.in_erase_sector &&
             (state == FWS_S_ERASE || state == FWS_S_SUSP)) begin
            tog2 <= ~tog2;                              // RULE22
         end
      end
   end

   // After completion one read shows true polling data; set wins.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         done_pend <= 1'b0;
      end else if (done_set) begin
         done_pend <= 1'b1;                             // RULE2
      end else if (rd_end || rst_low || state != FWS_S_IDLE) begin
         done_pend <= 1'b0;
      end
   end

   //=======================================================================
   // Status overlay.
   always_comb begin
      next_stat = o_stat;
      next_stat.timeout_fail_bit = 1'b0;
      next_stat.toggle_bit_one   = tog1;
      next_stat.toggle_bit_two   = tog2;
      case (state)
         FWS_S_PROG, FWS_S_SPROG: begin
            next_stat.drive         = i_rd.in_prog_bank; // RULE1
            next_stat.data_poll_bit = busy7;
         end
         FWS_S_PPROT, FWS_S_EPROT: begin
            next_stat.drive         = 1'b1;             // RULE8
            next_stat.data_poll_bit = busy7;
         end
         FWS_S_ERASE: begin
            next_stat.drive         = 1'b1;
            next_stat.data_poll_bit = 1'b0;             // RULE5
         end
         FWS_S_SUSP: begin
            next_stat.drive         = i_rd.in_erase_sector;
            next_stat.data_poll_bit = 1'b1;
         end
         FWS_S_FAIL: begin
            next_stat.drive            = 1'b1;
            next_stat.data_poll_bit    = busy7;
            next_stat.timeout_fail_bit = 1'b1;          // RULE24
         end
         FWS_S_IDLE: begin
            // Other bits may still be stale on this one read.
            next_stat.drive         = done_pend;        // RULE2 RULE7
            next_stat.data_poll_bit = done7;            // RULE5
         end
         default: next_stat.drive = 1'b0;               // RULE7
      endcase
   end

   //=======================================================================
   // Registered outputs.
   // Status, engine controls and rejection pulse.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_stat       <= '0;
         o_ctl        <= '0;
         o_cmd_reject <= 1'b0;
      end else begin
         o_stat       <= next_stat;
         o_ctl        <= next_ctl;
         o_cmd_reject <= next_reject;
      end
   end

   // Busy line pulled low in busy states, released otherwise.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_ready_busy_n_out  <= 1'b0;
         o_ready_busy_n_oe_n <= 1'b1;
      end else begin
         o_ready_busy_n_out  <= 1'b0;
         o_ready_busy_n_oe_n <= (next_state == FWS_S_IDLE) ||
                                (next_state == FWS_S_SUSP); // RULE12 RULE14
      end
   end

   // Reads stay blocked until the delay after reset release.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rh_cnt    <= '0;
         o_read_ok <= 1'b0;
      end else if (rst_low) begin
         rh_cnt    <= CW'(RH_CYC);
         o_read_ok <= 1'b0;                             // RULE16
      end else begin
         if (rh_cnt != '0) begin
            rh_cnt <= rh_cnt - CW'(1);
         end
         o_read_ok <= (rh_cnt == '0);
      end
   end

endmodule : fws_status_reporter

// ==== logic/fws_status_cfg.svh ====
//==========================================================================
// Summary of operation
// RULE1 - Program busy reads return inverted last bit.
// RULE2 - Next read after completion returns all valid.
// RULE3 - Chip erase polling valid after sixth strobe.
// RULE4 - Sector erase polling valid after last strobe.
// RULE5 - Erase polling reads zero, one when done.
// RULE6 - Host polls inside selected unprotected erase sectors.
// RULE7 - Status only in busy, suspend, time-out states.
// RULE8 - Protected program shows polling about one microsecond.
// RULE9 - Protected sector erase toggles about 150 microseconds.
// RULE10 - All selected protected toggles about 100 microseconds.
// RULE11 - Partial protection erases only the unprotected sectors.
// RULE12 - Busy line low while program, erase, reset run.
// RULE13 - Busy rejects program or erase except suspend.
// RULE14 - Erase suspend releases the busy line.
// RULE15 - Busy line falls at final command strobe edge.
// RULE16 - Hardware reset holds busy, then delays reads.
// RULE17 - First toggle bit flips per read while busy.
// RULE18 - First toggle valid from final strobe, any address.
// RULE19 - Read cycle ends by enable, chip select, valid.
// RULE20 - Toggle stops in suspend, runs during suspend program.
// RULE21 - Protected program toggles about one microsecond.
// RULE22 - Second toggle flips in selected erase sectors.
// RULE23 - Host rechecks polling bit after timeout bit.
// RULE24 - Pulse limit sets timeout bit until reset command.
//==========================================================================
`ifndef FWS_STATUS_CFG_SVH
`define FWS_STATUS_CFG_SVH

//==========================================================================
// Timing in nanoseconds and the system clock period.
//==========================================================================
`define FWS_CLK_NS        100
`define FWS_PROT_PROG_NS  1000
`define FWS_PROT_SECT_NS  150000
`define FWS_PROT_ALL_NS   100000
`define FWS_READY_NS      20000
`define FWS_RH_NS         200

//==========================================================================
// Counter width, pin slot positions and pin idle levels.
//==========================================================================
`define FWS_CNT_W     16
`define FWS_NPIN      6
`define FWS_PIN_WE    0
`define FWS_PIN_OE    1
`define FWS_PIN_CS    2
`define FWS_PIN_ADV   3
`define FWS_PIN_BCLK  4
`define FWS_PIN_RST   5
`define FWS_PIN_IDLE  6'h2F

`endif

// ==== logic/fws_pkg.sv ====
//==========================================================================
// Types shared by the status reporter and its neighbours.
//==========================================================================
package fws_pkg;

   // Command kinds handed over by the command decoder.
   typedef enum logic [2:0] {
      FWS_CMD_NONE   = 3'h0,
      FWS_CMD_PROG   = 3'h1,
      FWS_CMD_CHIP   = 3'h2,
      FWS_CMD_SECT   = 3'h3,
      FWS_CMD_SUSP   = 3'h4,
      FWS_CMD_RESUME = 3'h5,
      FWS_CMD_RESET  = 3'h6
   } fws_kind_t;

   // A decoded command waiting for its final write strobe edge.
   typedef struct packed {
      logic      valid;       // Command is present.
      fws_kind_t kind;        // What the command asks for.
      logic      data7;       // Top data bit of the program value.
      logic      target_prot; // Program target sector is protected.
      logic      all_prot;    // Every selected erase sector protected.
      logic      some_prot;   // At least one selected sector protected.
      logic      multi;       // More than one sector selected.
   } fws_cmd_t;

   // Events from the embedded algorithm engine.
   typedef struct packed {
      logic done;             // Algorithm finished.
      logic pulse_limit;      // Internal pulse count exceeded.
   } fws_eng_t;

   // Address qualifiers of the read in progress.
   typedef struct packed {
      logic in_prog_bank;     // Read hits the bank being programmed.
      logic in_erase_sector;  // Read hits a sector selected for erase.
   } fws_rd_t;

   // Status byte overlay; drive replaces array data with status.
   typedef struct packed {
      logic drive;
      logic data_poll_bit;
      logic toggle_bit_one;
      logic timeout_fail_bit;
      logic toggle_bit_two;
   } fws_stat_t;

   // One-cycle controls toward the algorithm engine.
   typedef struct packed {
      logic start_prog;
      logic start_erase;
      logic skip_prot;
      logic suspend;
      logic resume;
      logic abort;
   } fws_ctl_t;

   // Operating states, one-hot.
   typedef enum logic [8:0] {
      FWS_S_IDLE  = 9'h001,
      FWS_S_PROG  = 9'h002,
      FWS_S_ERASE = 9'h004,
      FWS_S_SUSP  = 9'h008,
      FWS_S_SPROG = 9'h010,
      FWS_S_PPROT = 9'h020,
      FWS_S_EPROT = 9'h040,
      FWS_S_FAIL  = 9'h080,
      FWS_S_RBUSY = 9'h100
   } fws_state_t;

endpackage : fws_pkg

// ==== verification/fws_checker.sv ====
//==========================================================================
// Port checker: busy line and status overlay against engine events.
module fws_checker
   import fws_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input fws_eng_t  i_eng,
   input fws_stat_t o_stat,
   input fws_ctl_t  o_ctl,
   input wire logic o_cmd_reject,
   input wire logic o_ready_busy_n_out,
   input wire logic o_ready_busy_n_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   property p_od; !o_ready_busy_n_out; endproperty
   a_od: assert property (p_od) else $error("busy pin high");
   property p_go; o_ctl.start_prog |-> !o_ready_busy_n_oe_n; endproperty
   a_go: assert property (p_go) else $error("start not busy");
   property p_idle; o_ctl.start_prog |-> $past(o_ready_busy_n_oe_n);
   endproperty
   a_idle: assert property (p_idle) else $error("start when busy");
   property p_susp; o_ctl.suspend |-> o_ready_busy_n_oe_n; endproperty
   a_susp: assert property (p_susp) else $error("suspend busy");
   property p_erase;
      o_ctl.start_erase |=> o_stat.drive && !o_stat.data_poll_bit;
   endproperty
   a_erase: assert property (p_erase) else $error("erase poll");
   property p_fail;
      i_eng.pulse_limit && !o_ready_busy_n_oe_n
         |-> ##[2:3] o_stat.timeout_fail_bit;
   endproperty
   a_fail: assert property (p_fail) else $error("no timeout bit");
   property p_done; i_eng.done && !o_ready_busy_n_oe_n |=> o_ready_busy_n_oe_n;
   endproperty
   a_done: assert property (p_done) else $error("busy after done");
   property p_rej; o_cmd_reject |-> $stable(o_ready_busy_n_oe_n); endproperty
   a_rej: assert property (p_rej) else $error("reject moved busy");
   c_prog: cover property (o_ctl.start_prog);
   c_erase: cover property (o_ctl.start_erase);
   c_rej: cover property (o_cmd_reject);
endmodule : fws_checker
bind fws_status_reporter fws_checker u_chk (.i_clk, .i_srst, .i_eng, .o_stat,
   .o_ctl, .o_cmd_reject, .o_ready_busy_n_out, .o_ready_busy_n_oe_n);

// ==== verification/fws_host_model.sv ====
//==========================================================================
// Host pin driver: asynchronous strobe writes and output-enable reads.
module fws_host_model (
   input  wire logic i_clk,
   output logic      o_we_n = 1'h1,
   output logic      o_oe_n = 1'h1,
   output logic      o_cs_n = 1'h1,
   output logic      o_adv_n,
   output logic      o_bclk
);
   timeunit 1ns;
   timeprecision 1ns;
   assign o_adv_n = 1'h1;
   assign o_bclk  = 1'h0;
   // Long phases let the pin synchronisers accept every level.
   task automatic wr;
      o_we_n <= 1'h0;
      repeat (10) @(posedge i_clk);
      o_we_n <= 1'h1;
      repeat (10) @(posedge i_clk);
   endtask : wr
   task automatic rd;
      {o_oe_n, o_cs_n} <= 2'h0;
      repeat (10) @(posedge i_clk);
      {o_oe_n, o_cs_n} <= 2'h3;
      repeat (10) @(posedge i_clk);
   endtask : rd
endmodule : fws_host_model

// ==== verification/testbench.sv ====
//==========================================================================
// Self-checking bench for the status reporter.
module testbench
   import fws_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 1'h0, i_srst = 1'h1, we_n, oe_n, cs_n, adv_n, bclk, t;
   logic rej, rok, rb_out, rb_oe_n, hw_n = 1'h1;
   fws_cmd_t cmd = '0;
   fws_eng_t eng = '0;
   fws_rd_t rd = '0;
   fws_stat_t st;
   fws_ctl_t ctl;
   int num_errors = 0, checks = 0, n_rej = 0, r;
   fws_host_model H (.i_clk, .o_we_n(we_n), .o_oe_n(oe_n), .o_cs_n(cs_n),
      .o_adv_n(adv_n), .o_bclk(bclk));
   fws_status_reporter #(.PROT_PROG_CYC(20), .PROT_SECT_CYC(20),
      .PROT_ALL_CYC(15), .READY_CYC(10)) DUT (.i_clk, .i_srst,
      .i_write_strobe_n(we_n), .i_output_enable_n(oe_n),
      .i_chip_select_n(cs_n), .i_address_valid_n(adv_n), .i_burst_clk(bclk),
      .i_hw_reset_n(hw_n), .i_sync_mode(1'h0), .i_cmd(cmd), .i_eng(eng),
      .i_rd(rd), .o_stat(st), .o_ctl(ctl), .o_cmd_reject(rej), .o_read_ok(rok),
      .o_ready_busy_n_out(rb_out), .o_ready_busy_n_oe_n(rb_oe_n));
   initial forever #50 i_clk = ~i_clk;
   always @(posedge i_clk) if (rej === 1'h1) n_rej++;
   task automatic cmp(string what, logic exp, logic got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp
   task automatic issue(fws_kind_t k, logic d7, logic tp);
      cmd <= '{1'h1, k, d7, tp, 1'h0, 1'h0, 1'h0};
      @(posedge i_clk);
      cmd.valid <= 1'h0;
      H.wr();
   endtask : issue
   task automatic pulse(logic lim);
      eng <= {~lim, lim};
      @(posedge i_clk);
      eng <= '0;
      repeat (3) @(posedge i_clk);
   endtask : pulse
   task automatic t_prog;
      rd <= 2'h2;
      issue(FWS_CMD_PROG, 1'h1, 1'h0);
      cmp("busy", 1'h0, rb_oe_n);
      cmp("poll", 1'h0, st.data_poll_bit);
      t = st.toggle_bit_one;
      H.rd();
      cmp("tog1", ~t, st.toggle_bit_one);
      r = n_rej;
      issue(FWS_CMD_CHIP, 1'h0, 1'h0);
      cmp("reject", 1'h1, n_rej == r + 1);
      pulse(1'h0);
      cmp("busy", 1'h1, rb_oe_n);
      cmp("poll", 1'h1, st.data_poll_bit);
      H.rd();
      cmp("drive", 1'h0, st.drive);
      $display("program test done");
   endtask : t_prog
   task automatic t_erase;
      rd <= 2'h1;
      issue(FWS_CMD_SECT, 1'h0, 1'h0);
      cmp("poll", 1'h0, st.data_poll_bit);
      t = st.toggle_bit_two;
      H.rd();
      cmp("tog2", ~t, st.toggle_bit_two);
      issue(FWS_CMD_SUSP, 1'h0, 1'h0);
      cmp("busy", 1'h1, rb_oe_n);
      t = st.toggle_bit_one;
      H.rd();
      cmp("tog1", t, st.toggle_bit_one);
      issue(FWS_CMD_RESUME, 1'h0, 1'h0);
      cmp("busy", 1'h0, rb_oe_n);
      pulse(1'h1);
      cmp("timeout", 1'h1, st.timeout_fail_bit);
      cmp("poll", 1'h0, st.data_poll_bit);
      issue(FWS_CMD_RESET, 1'h0, 1'h0);
      cmp("busy", 1'h1, rb_oe_n);
      $display("erase test done");
   endtask : t_erase
   task automatic t_prot;
      issue(FWS_CMD_PROG, 1'h0, 1'h1);
      cmp("drive", 1'h1, st.drive);
      repeat (30) @(posedge i_clk);
      H.rd();
      cmp("drive", 1'h0, st.drive);
      $display("protected test done");
   endtask : t_prot
   task automatic t_hwrst;
      issue(FWS_CMD_PROG, 1'h1, 1'h0);
      hw_n <= 1'h0;
      repeat (8) @(posedge i_clk);
      cmp("busy", 1'h0, rb_oe_n);
      cmp("read_ok", 1'h0, rok);
      hw_n <= 1'h1;
      repeat (20) @(posedge i_clk);
      cmp("busy", 1'h1, rb_oe_n);
      cmp("read_ok", 1'h1, rok);
      $display("hardware reset test done");
   endtask : t_hwrst
   task automatic conclude;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (3) @(posedge i_clk);
      i_srst <= 1'h0;
      repeat (5) @(posedge i_clk);
      cmp("read_ok", 1'h1, rok);
      t_prog();
      t_erase();
      t_prot();
      t_hwrst();
      conclude();
   end
   initial begin
      repeat (3000) @(posedge i_clk);
      num_errors++;
      conclude();
   end
endmodule : testbench
